// ---- logic/wdsc_top.sv ----
`timescale 1ns/1ps
`include "wdsc_params.svh"

module wdsc_top #(
   parameter int TICK_DIV = `WDSC_TICK_CYC
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Core events and configuration
   input  wire logic [1:0]  config_mode_i,
   input  wire logic        sleep_i,
   input  wire logic        kick_i,
   input  wire logic        osc_fail_i,
   input  wire logic        ost_running_i,
   input  wire logic        crystal_src_i,
   // Watchdog results
   output logic             wdt_reset_o,
   output logic             wake_o,
   output logic             timeout_flag_n_o,
   output logic             powerdown_flag_n_o,
   output logic             irq_o
);

   ////////////////////////////////////////////////////////////////////////

   localparam logic [9:0] DIV_LAST = 10'(TICK_DIV - 1);

   localparam wdsc_pkg::wdsc_state_s RST_STATE = '{
      psel:     `WDSC_PS_RESET,
      soft_en:  1'b0,
      cnt:      24'h000000,
      div:      10'h000,
      phase:    wdsc_pkg::WDSC_AWAKE,
      sts:      3'h0,
      ien:      3'h0,
      to_n:     1'b1,
      pd_n:     1'b1,
      ack:      1'b0,
      rdat:     32'h00000000,
      rst_pls:  1'b0,
      wake_pls: 1'b0
   };

   wdsc_pkg::wdsc_state_s s_q;
   wdsc_pkg::wdsc_state_s s_d;

   logic        tick;
   logic        asleep;
   logic        active;
   logic        clr;
   logic        hit;
   logic [4:0]  code;
   logic [23:0] thr;
   logic        req;
   logic        wr;
   logic [2:0]  ev_set;
   logic [2:0]  ev_clr;
   logic [7:0]  ctrl_rd;

   ////////////////////////////////////////////////////////////////////////

   always_comb begin
      s_d    = s_q;
      clr    = 1'b0;
      hit    = 1'b0;
      ev_set = 3'h0;
      ev_clr = 3'h0;

      s_d.rst_pls  = 1'b0;
      s_d.wake_pls = 1'b0;

      // Base tick of the low-frequency time base
      tick = (s_q.div == DIV_LAST);
      if (tick) begin
         s_d.div = 10'h000;
      end else begin
         s_d.div = s_q.div + 10'h001;
      end

      asleep = (s_q.phase == wdsc_pkg::WDSC_ASLEEP);

      // Mode decode
      case (config_mode_i)
         `WDSC_MODE_ON:    active = 1'b1;
         `WDSC_MODE_AWAKE: active = ~asleep;
         `WDSC_MODE_SOFT:  active = s_q.soft_en;
         default:          active = 1'b0;
      endcase

      // Reserved codes fall back to the shortest period
      if (s_q.psel > `WDSC_PS_MAX) begin
         code = 5'h00;
      end else begin
         code = s_q.psel;
      end
      thr = 24'h000001 << (6'(code) + `WDSC_PS_SHIFT);

      // Sleep sequencing
      case (s_q.phase)
         wdsc_pkg::WDSC_AWAKE: begin
            if (sleep_i) begin
               clr         = 1'b1;
               s_d.phase   = wdsc_pkg::WDSC_ASLEEP;
               s_d.pd_n    = 1'b0;
               s_d.to_n    = 1'b1;
            end
         end
         wdsc_pkg::WDSC_ASLEEP: begin
            if (!sleep_i) begin
               clr = 1'b1;
               // Crystal needs its start-up time before counting
               if (crystal_src_i && ost_running_i) begin
                  s_d.phase = wdsc_pkg::WDSC_OST_WAIT;
               end else begin
                  s_d.phase = wdsc_pkg::WDSC_AWAKE;
               end
            end
         end
         wdsc_pkg::WDSC_OST_WAIT: begin
            clr = 1'b1;
            if (sleep_i) begin
               s_d.phase = wdsc_pkg::WDSC_ASLEEP;
               s_d.pd_n  = 1'b0;
            end else if (!ost_running_i) begin
               s_d.phase = wdsc_pkg::WDSC_AWAKE;
            end
         end
         default: begin
            s_d.phase = wdsc_pkg::WDSC_AWAKE;
         end
      endcase

      if (kick_i) begin
         clr      = 1'b1;
         s_d.to_n = 1'b1;
         s_d.pd_n = 1'b1;
      end

      if (osc_fail_i) begin
         clr = 1'b1;
         ev_set[`WDSC_EV_OSC_FAIL] = 1'b1;
      end

      // Counter; divider select is not an input, so it cannot touch it
      if (clr || !active) begin
         s_d.cnt = 24'h000000;
      end else if (tick) begin
         if (s_q.cnt == thr - 24'h000001) begin
            hit     = 1'b1;
            s_d.cnt = 24'h000000;
         end else begin
            s_d.cnt = s_q.cnt + 24'h000001;
         end
      end

      // Timeout: reset while awake, wake-up while asleep
      if (hit) begin
         s_d.to_n = 1'b0;
         if (asleep) begin
            s_d.wake_pls = 1'b1;
            s_d.pd_n     = 1'b0;
            ev_set[`WDSC_EV_TO_SLEEP] = 1'b1;
         end else begin
            s_d.rst_pls = 1'b1;
            ev_set[`WDSC_EV_TO_AWAKE] = 1'b1;
         end
      end

      // Bus: ack one cycle after request, dropped the next
      req     = wb_cyc_i & wb_stb_i;
      s_d.ack = req & ~s_q.ack;
      wr      = req & wb_we_i & s_q.ack & wb_sel_i[0];

      ctrl_rd = {2'b00, s_q.psel, s_q.soft_en};

      if (s_d.ack) begin
         case (wb_adr_i)
            `WDSC_OFS_CTRL:   s_d.rdat = {24'h000000, ctrl_rd};
            `WDSC_OFS_STATUS: s_d.rdat = {29'h0, s_q.sts};
            `WDSC_OFS_ENABLE: s_d.rdat = {29'h0, s_q.ien};
            `WDSC_OFS_FLAGS:  s_d.rdat = {30'h0, s_q.to_n, s_q.pd_n};
            default:          s_d.rdat = 32'h00000000;
         endcase
      end

      if (wr) begin
         case (wb_adr_i)
            `WDSC_OFS_CTRL: begin
               // Top two bits are not stored
               s_d.psel = wb_dat_i[`WDSC_CTRL_PS_MSB:`WDSC_CTRL_PS_LSB];
               s_d.soft_en = wb_dat_i[`WDSC_CTRL_EN_BIT];
            end
            `WDSC_OFS_CLEAR:  ev_clr = wb_dat_i[2:0];
            `WDSC_OFS_ENABLE: s_d.ien = wb_dat_i[2:0];
            default: begin
            end
         endcase
      end

      // New events beat a clear in the same cycle
      s_d.sts = (s_q.sts & ~ev_clr) | ev_set;
   end

   ////////////////////////////////////////////////////////////////////////

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= RST_STATE;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////

   assign wb_dat_o           = s_q.rdat;
   assign wb_ack_o           = s_q.ack;
   assign wdt_reset_o        = s_q.rst_pls;
   assign wake_o             = s_q.wake_pls;
   assign timeout_flag_n_o   = s_q.to_n;
   assign powerdown_flag_n_o = s_q.pd_n;
   assign irq_o              = |(s_q.sts & s_q.ien);

endmodule : wdsc_top

// ---- logic/wdsc_params.svh ----
`ifndef WDSC_PARAMS_SVH
`define WDSC_PARAMS_SVH

// Register byte offsets
`define WDSC_OFS_CTRL    8'h00
`define WDSC_OFS_STATUS  8'h04
`define WDSC_OFS_CLEAR   8'h08
`define WDSC_OFS_ENABLE  8'h0C
`define WDSC_OFS_FLAGS   8'h10

// Control register fields
`define WDSC_CTRL_EN_BIT 0
`define WDSC_CTRL_PS_LSB 1
`define WDSC_CTRL_PS_MSB 5
`define WDSC_CTRL_RESET  8'h16
`define WDSC_PS_RESET    5'h0B
`define WDSC_PS_MAX      5'h12
`define WDSC_PS_SHIFT    6'h05

// Event bits of status, clear and enable
`define WDSC_EV_TO_AWAKE 0
`define WDSC_EV_TO_SLEEP 1
`define WDSC_EV_OSC_FAIL 2
`define WDSC_EV_N        3

// Configuration mode codes
`define WDSC_MODE_OFF    2'h0
`define WDSC_MODE_SOFT   2'h1
`define WDSC_MODE_AWAKE  2'h2
`define WDSC_MODE_ON     2'h3

// Timing
`define WDSC_CLK_NS      50
`define WDSC_TICK_NS     31250
`define WDSC_TICK_CYC    ((`WDSC_TICK_NS + `WDSC_CLK_NS - 1) / `WDSC_CLK_NS)

`endif

// ---- logic/wdsc_pkg.sv ----
package wdsc_pkg;

   typedef enum logic [1:0] {
      WDSC_AWAKE,
      WDSC_ASLEEP,
      WDSC_OST_WAIT
   } wdsc_phase_e;

   typedef struct packed {
      logic [4:0]  psel;
      logic        soft_en;
      logic [23:0] cnt;
      logic [9:0]  div;
      wdsc_phase_e phase;
      logic [2:0]  sts;
      logic [2:0]  ien;
      logic        to_n;
      logic        pd_n;
      logic        ack;
      logic [31:0] rdat;
      logic        rst_pls;
      logic        wake_pls;
   } wdsc_state_s;

endpackage : wdsc_pkg

// ---- test/wdsc_chk.sv ----
`timescale 1ns/1ps
module wdsc_chk (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave side
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_o,
   input  wire logic        wb_ack_o,
   // Core events and configuration
   input  wire logic [1:0]  config_mode_i,
   input  wire logic        sleep_i,
   input  wire logic        kick_i,
   input  wire logic        osc_fail_i,
   // Watchdog results
   input  wire logic        wdt_reset_o,
   input  wire logic        wake_o,
   input  wire logic        timeout_flag_n_o,
   input  wire logic        powerdown_flag_n_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack1: assert property (p_ack1) else $error("ack held");
   property p_rst; $fell(rst_i) |-> !wdt_reset_o && !wake_o &&
      timeout_flag_n_o && powerdown_flag_n_o; endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   property p_off; config_mode_i == 2'h0 |=> !wdt_reset_o && !wake_o;
   endproperty
   a_off: assert property (p_off) else $error("pulse while off");
   property p_kick; kick_i |=> !wdt_reset_o && !wake_o; endproperty
   a_kick: assert property (p_kick) else $error("pulse on kick");
   property p_kflg; kick_i |=> timeout_flag_n_o && powerdown_flag_n_o;
   endproperty
   a_kflg: assert property (p_kflg) else $error("flags after kick");
   property p_osc; osc_fail_i |=> !wdt_reset_o && !wake_o; endproperty
   a_osc: assert property (p_osc) else $error("pulse on osc fail");
   property p_slp; $rose(sleep_i) |=> !powerdown_flag_n_o; endproperty
   a_slp: assert property (p_slp) else $error("no powerdown flag");
   property p_nrst; sleep_i ##1 sleep_i |=> !wdt_reset_o; endproperty
   a_nrst: assert property (p_nrst) else $error("reset in sleep");
   property p_wake; wake_o |-> !timeout_flag_n_o && !powerdown_flag_n_o;
   endproperty
   a_wake: assert property (p_wake) else $error("flags on wake");
   property p_b76; wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |->
      wb_dat_o[31:6] == 26'h0; endproperty
   a_b76: assert property (p_b76) else $error("ctrl top bits");
endmodule : wdsc_chk

bind wdsc_top wdsc_chk wdsc_chk_i (.*);

// ---- test/wdsc_top_bench.sv ----
`timescale 1ns/1ps
module wdsc_top_bench;
   localparam int TD = 2;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0, sleep_i = 1'b0, kick_i = 1'b0, osc_fail_i = 1'b0;
   logic ost_running_i = 1'b0, crystal_src_i = 1'b0;
   logic [1:0]  config_mode_i = 2'h0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic wb_ack_o, wdt_reset_o, wake_o, timeout_flag_n_o;
   logic powerdown_flag_n_o, irq_o;
   int miscompares = 0, compares = 0, cyc_n = 0, t0 = 0, d, c;
   logic [31:0] rq[$];
   logic [1:0]  ek[$];
   int          ec[$];
   wdsc_top #(.TICK_DIV(TD)) wdsc_top_i (.*);
   ////////////////////////////////////////////////////////////////////////
   task automatic ck(input logic [31:0] a, input logic [31:0] e);
      compares++;
      if (a !== e) begin
         miscompares++;
         $display("[ERR] t=%0t got %h exp %h", $time, a, e);
      end
   endtask : ck
   task automatic report_and_stop;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] v);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= v;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask : rd
   // Expect one pulse of kind k after n ticks, then stop the count
   task automatic ev(input logic [1:0] k, input int n);
      ek.push_back(k);
      ec.push_back(n * TD);
      t0 = cyc_n;
      wait (ek.size() == 0);
      @(posedge clk_i);
      config_mode_i <= 2'h0;
      @(posedge clk_i);
   endtask : ev
   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   // Any pulse with no note pending is a mismatch
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (wb_ack_o && !wb_we_i) ck(wb_dat_o, rq.pop_front());
      if (wdt_reset_o || wake_o) begin
         if (ek.size() == 0) ck(32'({wake_o, wdt_reset_o}), 32'h0);
         else begin
            d = cyc_n - t0 - ec.pop_front();
            ck(32'({wake_o, wdt_reset_o}), 32'(ek.pop_front()));
            ck(32'(d > -4 - 3 * TD && d < 4 + 3 * TD), 32'h1);
         end
      end
      if (cyc_n > 20000) begin
         miscompares++;
         report_and_stop();
      end
   end
   initial begin
      void'($urandom(32'h059E));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(8'h00, 32'h16);
      rd(8'h10, 32'h3);
      rd(8'h20, 32'h0);
      bus(1'b1, 8'h00, 32'hFF);
      rd(8'h00, 32'h3F);
      $display("end regs");
      bus(1'b1, 8'h00, 32'h0);
      config_mode_i <= 2'h1;
      repeat (150) @(posedge clk_i);
      bus(1'b1, 8'h00, 32'h1);
      config_mode_i <= 2'h0;
      repeat (150) @(posedge clk_i);
      $display("end hold");
      for (int i = 0; i < 4; i++) begin
         c = (i == 3) ? 19 + $urandom % 13 : i;
         bus(1'b1, 8'h00, 32'(c * 2 + 1));
         config_mode_i <= 2'h1;
         @(posedge clk_i);
         kick_i <= 1'b1;
         @(posedge clk_i);
         kick_i <= 1'b0;
         ev(2'h1, 1 << ((c > 18 ? 0 : c) + 5));
      end
      rd(8'h04, 32'h1);
      bus(1'b1, 8'h0C, 32'h1);
      @(posedge clk_i);
      ck(32'(irq_o), 32'h1);
      bus(1'b1, 8'h0C, 32'h6);
      @(posedge clk_i);
      ck(32'(irq_o), 32'h0);
      bus(1'b1, 8'h08, 32'h1);
      rd(8'h04, 32'h0);
      $display("end period");
      bus(1'b1, 8'h00, 32'h0);
      config_mode_i <= 2'h3;
      // Gaps stay below the 64-cycle period of code 0
      for (int i = 0; i < 12; i++) begin
         repeat (20 + $urandom % 30) @(posedge clk_i);
         if (i < 6) kick_i <= 1'b1;
         else osc_fail_i <= 1'b1;
         @(posedge clk_i);
         kick_i     <= 1'b0;
         osc_fail_i <= 1'b0;
      end
      config_mode_i <= 2'h0;
      @(posedge clk_i);
      ck(32'(irq_o), 32'h1);
      rd(8'h04, 32'h4);
      $display("end kick");
      config_mode_i <= 2'h3;
      sleep_i       <= 1'b1;
      ev(2'h2, 32);
      rd(8'h10, 32'h0);
      sleep_i <= 1'b0;
      @(posedge clk_i);
      config_mode_i <= 2'h2;
      crystal_src_i <= 1'b1;
      ost_running_i <= 1'b1;
      sleep_i       <= 1'b1;
      repeat (150) @(posedge clk_i);
      sleep_i <= 1'b0;
      repeat (150) @(posedge clk_i);
      ost_running_i <= 1'b0;
      ev(2'h1, 32);
      config_mode_i <= 2'h2;
      crystal_src_i <= 1'b0;
      ost_running_i <= 1'b1;
      sleep_i       <= 1'b1;
      repeat (20) @(posedge clk_i);
      sleep_i <= 1'b0;
      ev(2'h1, 32);
      $display("end sleep");
      // Mid-run reset must drop a half-way count
      config_mode_i <= 2'h3;
      repeat (40) @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(8'h00, 32'h16);
      bus(1'b1, 8'h00, 32'h0);
      ev(2'h1, 32);
      $display("end reset");
      report_and_stop();
   end
endmodule : wdsc_top_bench
